// ---- rtl/pin_select_pkg.sv ----
// Constants for the remappable pin selection block
package pin_select_pkg;

  localparam int ADDR_W         = 12;
  localparam int DATA_W         = 32;
  localparam int SEL_W          = 4;
  localparam int NUM_OUT_PINS   = 32;
  localparam int NUM_IN_FUNCS   = 24;
  localparam int PINS_PER_GROUP = 8;
  localparam int NUM_PERIPH     = 17;
  localparam int PERIPH_IDX_W   = 5;
  localparam int REG_IDX_LSB    = 2;
  localparam int REG_IDX_W      = 5;
  localparam int REGION_LSB     = 7;

  // Register map
  localparam logic [ADDR_W-1:0] CFG_CTRL_ADDR = 12'h000;
  localparam logic [ADDR_W-1:0] IN_SEL_BASE   = 12'h100;
  localparam logic [ADDR_W-1:0] OUT_SEL_BASE  = 12'h200;
  localparam int                LOCK_BIT      = 13;
  localparam logic [SEL_W-1:0]  SEL_RESET     = 4'h0;
  localparam logic              LOCK_RESET    = 1'b0;

  // Input function index ranges per pin group
  localparam int IN_G1_FIRST = 5;
  localparam int IN_G2_FIRST = 11;
  localparam int IN_G3_FIRST = 19;

  // Peripheral output vector positions; position 0 means nothing mapped
  localparam logic [PERIPH_IDX_W-1:0] P_NONE         = 5'h00;
  localparam logic [PERIPH_IDX_W-1:0] P_UART1_TX     = 5'h01;
  localparam logic [PERIPH_IDX_W-1:0] P_UART2_RTS    = 5'h02;
  localparam logic [PERIPH_IDX_W-1:0] P_SPI1_SS      = 5'h03;
  localparam logic [PERIPH_IDX_W-1:0] P_CMP_OUT1     = 5'h04;
  localparam logic [PERIPH_IDX_W-1:0] P_CMPR2_OUT    = 5'h05;
  localparam logic [PERIPH_IDX_W-1:0] P_SPI1_SDO     = 5'h06;
  localparam logic [PERIPH_IDX_W-1:0] P_SPI2_SDO     = 5'h07;
  localparam logic [PERIPH_IDX_W-1:0] P_CMP_OUT2     = 5'h08;
  localparam logic [PERIPH_IDX_W-1:0] P_CMPR3_OUT    = 5'h09;
  localparam logic [PERIPH_IDX_W-1:0] P_CMP_OUT4     = 5'h0a;
  localparam logic [PERIPH_IDX_W-1:0] P_CMP_OUT5     = 5'h0b;
  localparam logic [PERIPH_IDX_W-1:0] P_REF_CLK_OUT  = 5'h0c;
  localparam logic [PERIPH_IDX_W-1:0] P_UART1_RTS    = 5'h0d;
  localparam logic [PERIPH_IDX_W-1:0] P_UART2_TX     = 5'h0e;
  localparam logic [PERIPH_IDX_W-1:0] P_SPI2_SS      = 5'h0f;
  localparam logic [PERIPH_IDX_W-1:0] P_CMP_OUT3     = 5'h10;
  localparam logic [PERIPH_IDX_W-1:0] P_CMPR1_OUT    = 5'h11;

  // Output selector codes
  localparam logic [SEL_W-1:0] CODE_1 = 4'h1;
  localparam logic [SEL_W-1:0] CODE_2 = 4'h2;
  localparam logic [SEL_W-1:0] CODE_3 = 4'h3;
  localparam logic [SEL_W-1:0] CODE_4 = 4'h4;
  localparam logic [SEL_W-1:0] CODE_5 = 4'h5;
  localparam logic [SEL_W-1:0] CODE_6 = 4'h6;
  localparam logic [SEL_W-1:0] CODE_7 = 4'h7;

endpackage

// ---- rtl/remappable_pin_select.sv ----
// Remappable pin selection: selector registers, output pin mux and input source mux
//
// Function
// - Group 0 pins: 0 none, 1 uart1 tx, 2 uart2 rts, 3 spi1 ss, 5 compare1, 7 comparator2.
// - Group 1 pins: 0 none, 3 spi1 out, 4 spi2 out, 5 compare2, 7 comparator3.
// - Group 2 pins: 0 none, 3 spi1 out, 4 spi2 out, 5 compare4, 6 compare5, 7 ref clock.
// - Group 3 pins: 0 none, 1 uart1 rts, 2 uart2 tx, 4 spi2 ss, 5 compare3, 7 comparator1.
// - Each input selection register keeps a 4-bit source field in bits 3..0, reset zero, upper bits read zero.
// - Each output pin register keeps a 4-bit selector in bits 3..0, reset zero, upper bits read zero.
// - Mapping registers change only while the pin map lock, control bit 13, is clear.
// - A mapping write while locked completes normally but stores nothing.
// - With the single session option active, a set lock cannot be cleared until reset.
// - A mapped peripheral overrides other digital pin functions but never an analog one.
// - After reset every remappable output is disconnected from every pin.
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ps

module remappable_pin_select
  import pin_select_pkg::*;
(
  input  wire logic                                core_clk,
  input  wire logic                                reset,
  input  wire logic [pin_select_pkg::ADDR_W-1:0]   regAddr,
  input  wire logic [pin_select_pkg::DATA_W-1:0]   regWriteData,
  input  wire logic                                regWrite,
  input  wire logic                                regRead,
  output logic      [pin_select_pkg::DATA_W-1:0]   regReadData,
  input  wire logic                                singleSessionLockOption,
  input  wire logic [pin_select_pkg::NUM_PERIPH:1] periphOut,
  output logic      [pin_select_pkg::NUM_IN_FUNCS-1:0] periphIn,
  input  wire logic [pin_select_pkg::NUM_OUT_PINS-1:0] padIn,
  input  wire logic [pin_select_pkg::NUM_OUT_PINS-1:0] defaultOut,
  input  wire logic [pin_select_pkg::NUM_OUT_PINS-1:0] defaultOe,
  input  wire logic [pin_select_pkg::NUM_OUT_PINS-1:0] analogSel,
  output logic      [pin_select_pkg::NUM_OUT_PINS-1:0] padOut,
  output logic      [pin_select_pkg::NUM_OUT_PINS-1:0] padOe,
  output logic      [pin_select_pkg::NUM_OUT_PINS-1:0] pinRemapped,
  output logic                                     pinMapLock
);
  import pin_select_pkg::*;

  logic [SEL_W-1:0]     outSel_reg [NUM_OUT_PINS];
  logic [SEL_W-1:0]     inSel_reg  [NUM_IN_FUNCS];
  logic                 lock_reg;
  logic [DATA_W-1:0]    readData_reg;
  logic [DATA_W-1:0]    readData_next;
  logic [NUM_PERIPH:0]  periphVec;
  logic [REG_IDX_W-1:0] regIdx;
  logic                 aligned;
  logic                 cfgHit;
  logic                 inHit;
  logic                 outHit;
  logic                 mapWriteOk;

  // Output selector decode per pin group; anything unlisted is no connection
  function automatic logic [PERIPH_IDX_W-1:0] routeOut(input int group,
                                                       input logic [SEL_W-1:0] code);
    logic [PERIPH_IDX_W-1:0] idx;
    idx = P_NONE;
    case (group)
      0:
      begin
        case (code)
          CODE_1:  idx = P_UART1_TX;
          CODE_2:  idx = P_UART2_RTS;
          CODE_3:  idx = P_SPI1_SS;
          CODE_5:  idx = P_CMP_OUT1;
          CODE_7:  idx = P_CMPR2_OUT;
          default: idx = P_NONE;
        endcase
      end
      1:
      begin
        case (code)
          CODE_3:  idx = P_SPI1_SDO;
          CODE_4:  idx = P_SPI2_SDO;
          CODE_5:  idx = P_CMP_OUT2;
          CODE_7:  idx = P_CMPR3_OUT;
          default: idx = P_NONE;
        endcase
      end
      2:
      begin
        case (code)
          CODE_3:  idx = P_SPI1_SDO;
          CODE_4:  idx = P_SPI2_SDO;
          CODE_5:  idx = P_CMP_OUT4;
          CODE_6:  idx = P_CMP_OUT5;
          CODE_7:  idx = P_REF_CLK_OUT;
          default: idx = P_NONE;
        endcase
      end
      3:
      begin
        case (code)
          CODE_1:  idx = P_UART1_RTS;
          CODE_2:  idx = P_UART2_TX;
          CODE_4:  idx = P_SPI2_SS;
          CODE_5:  idx = P_CMP_OUT3;
          CODE_7:  idx = P_CMPR1_OUT;
          default: idx = P_NONE;
        endcase
      end
      default: idx = P_NONE;
    endcase
    return idx;
  endfunction

  // Slot zero is a constant low so an unmapped pin reads a defined value
  assign periphVec = {periphOut, 1'b0};

  // Address decode: one aligned word per register
  assign regIdx  = regAddr[REG_IDX_LSB +: REG_IDX_W];
  assign aligned = (regAddr[REG_IDX_LSB-1:0] == '0);
  assign cfgHit  = aligned && (regAddr == CFG_CTRL_ADDR);
  assign inHit   = aligned
                   && (regAddr[ADDR_W-1:REGION_LSB] == IN_SEL_BASE[ADDR_W-1:REGION_LSB])
                   && (32'(regIdx) < NUM_IN_FUNCS);
  assign outHit  = aligned
                   && (regAddr[ADDR_W-1:REGION_LSB] == OUT_SEL_BASE[ADDR_W-1:REGION_LSB]);

  // Locked writes are swallowed silently; the bus never sees an error
  assign mapWriteOk = regWrite && !lock_reg;

  // Lock bit; a set lock sticks when the single session option is on
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      lock_reg <= LOCK_RESET;
    else if (regWrite && cfgHit)
    begin
      if (regWriteData[LOCK_BIT])
        lock_reg <= 1'b1;
      else if (!(singleSessionLockOption && lock_reg))
        lock_reg <= 1'b0;
    end
  end

  assign pinMapLock = lock_reg;

  // Output pin selectors
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      for (int i = 0; i < NUM_OUT_PINS; i++)
        outSel_reg[i] <= SEL_RESET;
    end
    else if (mapWriteOk && outHit)
      outSel_reg[regIdx] <= regWriteData[SEL_W-1:0];
  end

  // Input source selectors
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      for (int i = 0; i < NUM_IN_FUNCS; i++)
        inSel_reg[i] <= SEL_RESET;
    end
    else if (mapWriteOk && inHit)
      inSel_reg[regIdx] <= regWriteData[SEL_W-1:0];
  end

  // Read path: upper bits are unimplemented and stay zero
  always_comb
  begin
    readData_next = '0;
    if (regRead)
    begin
      if (cfgHit)
        readData_next[LOCK_BIT] = lock_reg;
      else if (inHit)
        readData_next[SEL_W-1:0] = inSel_reg[regIdx];
      else if (outHit)
        readData_next[SEL_W-1:0] = outSel_reg[regIdx];
    end
  end

  // Data is held only in the cycle after the read strobe
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      readData_reg <= '0;
    else
      readData_reg <= readData_next;
  end

  assign regReadData = readData_reg;

  // Output pin mux, one per pin
  genvar gp;
  generate
    for (gp = 0; gp < NUM_OUT_PINS; gp++)
    begin : g_out
      logic [PERIPH_IDX_W-1:0] idx;
      logic                    active;
      assign idx    = routeOut(gp / PINS_PER_GROUP, outSel_reg[gp]);
      assign active = (idx != P_NONE) && !analogSel[gp];
      assign pinRemapped[gp] = active;
      // Analog use releases the driver regardless of mapping
      assign padOe[gp]  = analogSel[gp] ? 1'b0
                          : (active ? 1'b1 : defaultOe[gp]);
      assign padOut[gp] = active ? periphVec[idx] : defaultOut[gp];
    end
  endgenerate

  // Input source mux; codes 8 and up are reserved and give a low input
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN_FUNCS; gi++)
    begin : g_in
      localparam int GROUP = (gi >= IN_G3_FIRST) ? 3
                             : (gi >= IN_G2_FIRST) ? 2
                             : (gi >= IN_G1_FIRST) ? 1 : 0;
      logic [REG_IDX_W-1:0] pin;
      assign pin = REG_IDX_W'(GROUP * PINS_PER_GROUP)
                   + REG_IDX_W'(inSel_reg[gi][SEL_W-2:0]);
      // Digital input buffer is off on an analog pin
      assign periphIn[gi] = !inSel_reg[gi][SEL_W-1]
                            && padIn[pin] && !analogSel[pin];
    end
  endgenerate

endmodule

// ---- test/periph_model.sv ----
// Stand-in for the on-chip peripherals and the package pins
`timescale 1ns/1ps
module periph_model
(
  input  wire logic                                    core_clk,
  input  wire logic                                    reset,
  output logic      [pin_select_pkg::NUM_PERIPH:1]     periphOut,
  output logic      [pin_select_pkg::NUM_OUT_PINS-1:0] padIn
);
  import pin_select_pkg::*;
  // Rings keep every line moving, so a wrong route cannot hide behind a still level
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      periphOut <= 17'h0a5a5;
      padIn     <= 32'h3c96_5a0f;
    end
    else
    begin
      periphOut <= {periphOut[16:1], ~periphOut[17]};
      padIn     <= {padIn[30:0], ~padIn[31]};
    end
  end
endmodule

// ---- test/pin_select_asserts.sv ----
// Port checker for the remappable pin selection block
`timescale 1ns/1ps
module pin_select_asserts
(
  input wire logic                                    core_clk,
  input wire logic                                    reset,
  input wire logic [pin_select_pkg::ADDR_W-1:0]       regAddr,
  input wire logic [pin_select_pkg::DATA_W-1:0]       regWriteData,
  input wire logic                                    regWrite,
  input wire logic                                    regRead,
  input wire logic [pin_select_pkg::DATA_W-1:0]       regReadData,
  input wire logic                                    singleSessionLockOption,
  input wire logic [pin_select_pkg::NUM_OUT_PINS-1:0] defaultOut,
  input wire logic [pin_select_pkg::NUM_OUT_PINS-1:0] analogSel,
  input wire logic [pin_select_pkg::NUM_OUT_PINS-1:0] padOut,
  input wire logic [pin_select_pkg::NUM_OUT_PINS-1:0] padOe,
  input wire logic [pin_select_pkg::NUM_OUT_PINS-1:0] pinRemapped,
  input wire logic                                    pinMapLock
);
  import pin_select_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence ctrlWrite; regWrite && regAddr == CFG_CTRL_ADDR; endsequence
  sequence lockedMapWrite; pinMapLock && regWrite && regAddr != CFG_CTRL_ADDR; endsequence
  AST_LOCK_WRITE: assert property (ctrlWrite |=> pinMapLock == ($past(regWriteData[13]) ||
    ($past(singleSessionLockOption) && $past(pinMapLock)))) else $error("lock bit wrong");
  AST_ONE_WAY: assert property (singleSessionLockOption && pinMapLock |=> pinMapLock)
    else $error("lock cleared in one-way mode");
  AST_LOCKED_MAP: assert property (lockedMapWrite |=> $stable(pinRemapped) || $changed(analogSel))
    else $error("locked write changed routing");
  AST_UPPER_ZERO: assert property (regRead && regAddr >= IN_SEL_BASE |=> regReadData[31:4] == '0)
    else $error("upper bits not zero");
  AST_LOCK_READ: assert property (regRead && regAddr == CFG_CTRL_ADDR |=>
    regReadData == {18'h0, $past(pinMapLock), 13'h0}) else $error("control read wrong");
  AST_ANALOG: assert property ((analogSel & (padOe | pinRemapped)) == '0)
    else $error("analog pin driven");
  AST_MAPPED_OE: assert property ((pinRemapped & ~padOe) == '0) else $error("mapped pin idle");
  AST_DEFAULT: assert property (((padOut ^ defaultOut) & ~pinRemapped & ~analogSel) == '0)
    else $error("default drive lost");
  AST_RESET_EMPTY: assert property ($fell(reset) |-> pinRemapped == '0 && !pinMapLock)
    else $error("mapping left after reset");
endmodule

bind remappable_pin_select pin_select_asserts pin_select_asserts_i (.core_clk(core_clk),
  .reset(reset), .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite),
  .regRead(regRead), .regReadData(regReadData), .defaultOut(defaultOut),
  .singleSessionLockOption(singleSessionLockOption), .analogSel(analogSel),
  .padOut(padOut), .padOe(padOe), .pinRemapped(pinRemapped), .pinMapLock(pinMapLock));

// ---- test/tb.sv ----
// Self-checking bench for the remappable pin selection block
`timescale 1ns/1ps
module tb;
  import pin_select_pkg::*;
  logic                    core_clk, reset, regWrite, regRead, singleSessionLockOption, pinMapLock;
  logic [ADDR_W-1:0]       regAddr;
  logic [DATA_W-1:0]       regWriteData, regReadData;
  logic [NUM_PERIPH:1]     periphOut;
  logic [NUM_IN_FUNCS-1:0] periphIn;
  logic [NUM_OUT_PINS-1:0] padIn, defaultOut, defaultOe, analogSel, padOut, padOe, pinRemapped;
  int                      fails, totalChecks;
  // Peripheral position per group and code, 0 meaning no connection
  int outMap [4][8] = '{'{0,1,2,3,0,4,0,5}, '{0,0,0,6,7,8,0,9}, '{0,0,0,6,7,10,11,12},
                        '{0,13,14,0,15,16,0,17}};
  remappable_pin_select remappable_pin_select_i (.core_clk(core_clk), .reset(reset),
    .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
    .regReadData(regReadData), .singleSessionLockOption(singleSessionLockOption),
    .periphOut(periphOut), .periphIn(periphIn), .padIn(padIn), .defaultOut(defaultOut),
    .defaultOe(defaultOe), .analogSel(analogSel), .padOut(padOut), .padOe(padOe),
    .pinRemapped(pinRemapped), .pinMapLock(pinMapLock));
  periph_model periph_model_i (.core_clk(core_clk), .reset(reset), .periphOut(periphOut),
    .padIn(padIn));
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    totalChecks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] exp, string what);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 chk(what, exp, regReadData);
  endtask
  // Two looks, since the peripheral lines move every cycle
  task automatic pinChk(int p, int pos);
    repeat (2)
    begin
      chk("padOut", pos ? periphOut[pos] : defaultOut[p], padOut[p]);
      chk("pinRemapped", pos != 0, pinRemapped[p]);
      chk("padOe", pos ? 1'b1 : defaultOe[p] & ~analogSel[p], padOe[p]);
      @(posedge core_clk);
      #1;
    end
  endtask
  task automatic testReset;
    chk("pinRemapped", 32'h0, pinRemapped);
    rd(OUT_SEL_BASE + 12'h07c, 32'h0, "outSel");
    rd(IN_SEL_BASE + 12'h05c, 32'h0, "inSel");
    rd(12'h300, 32'h0, "unmapped");
    $display("reset test done");
  endtask
  task automatic testOutMap;
    for (int c = 0; c < 16; c++)
      for (int g = 0; g < 4; g++)
      begin
        wr(OUT_SEL_BASE + 12'((g * 8 + c % 8) * 4), 32'hffff_fff0 | c);
        rd(OUT_SEL_BASE + 12'((g * 8 + c % 8) * 4), c, "outSel");
        pinChk(g * 8 + c % 8, c < 8 ? outMap[g][c] : 0);
      end
    $display("output map test done");
  endtask
  task automatic testInMap;
    int g;
    for (int i = 0; i < NUM_IN_FUNCS; i++)
    begin
      g = (i >= IN_G1_FIRST) + (i >= IN_G2_FIRST) + (i >= IN_G3_FIRST);
      wr(IN_SEL_BASE + 12'(i * 4), 32'hffff_fff0 | (i % 8));
      rd(IN_SEL_BASE + 12'(i * 4), i % 8, "inSel");
      chk("periphIn", padIn[g * 8 + i % 8], periphIn[i]);
      wr(IN_SEL_BASE + 12'(i * 4), 32'h9);
      chk("periphInReserved", 32'h0, periphIn[i]);
    end
    $display("input map test done");
  endtask
  task automatic testAnalog;
    wr(OUT_SEL_BASE + 12'h004, 32'h3);
    wr(IN_SEL_BASE, 32'h1);
    analogSel <= 32'h2;
    #1 chk("analogOe", 32'h0, padOe[1]);
    chk("analogIn", 32'h0, periphIn[0]);
    pinChk(1, 0);
    analogSel <= 32'h0;
    #1 pinChk(1, 3);
    chk("mappedOe", 32'h1, padOe[1]);
    $display("analog test done");
  endtask
  task automatic testLock;
    wr(OUT_SEL_BASE, 32'h1);
    wr(CFG_CTRL_ADDR, 32'h2000);
    chk("pinMapLock", 32'h1, pinMapLock);
    wr(OUT_SEL_BASE, 32'h7);
    wr(IN_SEL_BASE, 32'h3);
    rd(OUT_SEL_BASE, 32'h1, "lockedOut");
    rd(IN_SEL_BASE, 32'h1, "lockedIn");
    rd(CFG_CTRL_ADDR, 32'h2000, "ctrl");
    singleSessionLockOption <= 1'b1;
    wr(CFG_CTRL_ADDR, 32'h0);
    chk("oneWayLock", 32'h1, pinMapLock);
    singleSessionLockOption <= 1'b0;
    wr(CFG_CTRL_ADDR, 32'h0);
    wr(OUT_SEL_BASE, 32'h7);
    rd(OUT_SEL_BASE, 32'h7, "unlockedOut");
    singleSessionLockOption <= 1'b1;
    wr(CFG_CTRL_ADDR, 32'h2000);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    #1 chk("lockAfterReset", 32'h0, pinMapLock);
    chk("remapAfterReset", 32'h0, pinRemapped);
    $display("lock test done");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    reset = 1'b1;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = '0;
    regWriteData = '0;
    singleSessionLockOption = 1'b0;
    analogSel = '0;
    defaultOut = 32'h5555_aaaa;
    defaultOe = 32'hffff_0f0f;
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    #1 testReset;
    testOutMap;
    testInMap;
    testAnalog;
    testLock;
    give_verdict;
  end
  // Whole run needs about 600 cycles; this is over thirty times that
  initial
  begin
    #200000;
    fails++;
    give_verdict;
  end
endmodule
